/* core/rt_ctl_pkg.sv */
// Notes on behaviour
// (R1) any unique address 0 to 30 accepted
// (R2) address comes from wired connector pins
// (R3) address sampled, checked at power-up, fault tolerant
// (R4) invalid address: terminal never responds
// (R5) mode subaddress 00000 and 11111 mean same
// (R6) controller may use either mode subaddress
// (R7) status, shutdown, override, reset mode codes decoded
// (R8) controller issues all codes, never dynamic control
// (R9) reset: status word first, then internal reset
// (R10) during reset: busy status, no bad data
// (R11) reset finished within 5.0 ms
// (R12) self test: status word first, then test
// (R13) valid command may abort running self test
// (R14) during self test: busy status, no bad data
// (R15) self test results ready within 100.0 ms
// (R16) status word content always valid
// (R17) message error kept; instrumentation, reserved zero
// (R18) broadcast option implements broadcast received bit
// (R19) subsystem self test gives subsystem flag
// (R20) terminal self test gives terminal flag
// (R21) dynamic control unsupported, acceptance bit zero
// (R22) busy only from commands or faults
// (R23) address 11111 reserved for broadcast only
package rt_ctl_pkg;

    // apb register map
    localparam logic [11:0] off_ctrl = 12'h000;
    localparam logic [11:0] off_status = 12'h004;
    localparam logic [11:0] off_result = 12'h008;
    localparam int ctrl_bcast_bit = 0;
    localparam int ctrl_test_bit = 1;
    localparam int ctrl_sreq_bit = 2;
    localparam logic [2:0] ctrl_reset = 3'h3;
    localparam int stat_addr_ok_bit = 16;
    localparam int stat_tx_off_lsb = 17;
    localparam int stat_busy_bit = 19;
    localparam int stat_fail_bit = 20;

    // bus word fields
    localparam logic [4:0] addr_bcast = 5'h1f;
    localparam logic [4:0] sa_mode_lo = 5'h00;
    localparam logic [4:0] sa_mode_hi = 5'h1f;
    localparam logic [4:0] mc_tx_status = 5'h02;
    localparam logic [4:0] mc_self_test = 5'h03;
    localparam logic [4:0] mc_tx_shutdown = 5'h04;
    localparam logic [4:0] mc_tx_override = 5'h05;
    localparam logic [4:0] mc_reset_rt = 5'h08;

    // address acquisition spacing in cycles
    localparam logic [3:0] acq_settle = 4'h8;

    // deadlines
    localparam int clk_period_ps = 8000;
    localparam real reset_limit_ms = 5.0;
    localparam real test_limit_ms = 100.0;
    localparam int reset_limit_cycles = int'($floor(reset_limit_ms * 1.0e9 / clk_period_ps));
    localparam int test_limit_cycles = int'($floor(test_limit_ms * 1.0e9 / clk_period_ps));

    typedef enum logic [2:0] {
        ph_acquire,
        ph_check,
        ph_idle,
        ph_reset_wait,
        ph_reset,
        ph_test_wait,
        ph_test,
        ph_dead
    } phase_type;

    typedef struct packed {
        logic valid;
        logic bus;
        logic [4:0] rt_addr;
        logic tx;
        logic [4:0] subaddr;
        logic [4:0] mode;
    } cmd_type;

    typedef struct packed {
        logic valid;
        logic bus;
        logic [15:0] word;
    } resp_type;

endpackage

/* core/rt_option_mode_status_logic.sv */
`timescale 1ns/1ps
module rt_option_mode_status_logic
    import rt_ctl_pkg::*;
#(
    parameter int unsigned reset_cycles = reset_limit_cycles,
    parameter int unsigned test_cycles = test_limit_cycles
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // wired address connector
    input wire logic [4:0] addr_pin,
    input wire logic addr_par_pin,
    // from word decoder
    input wire cmd_type cmd,
    input wire logic msg_error,
    input wire logic subsys_fault,
    // to word encoder
    output resp_type resp,
    input wire logic resp_sent,
    // terminal state
    output logic [1:0] tx_enable,
    output logic addr_valid,
    output logic busy
);

    typedef struct packed {
        logic [5:0] sync1;
        logic [5:0] sync2;
        phase_type phase;
        logic [3:0] acq_cnt;
        logic [4:0] addr_a;
        logic [4:0] addr_b;
        logic par_a;
        logic addr_ok;
        logic [23:0] cnt;
        logic [1:0] tx_off;
        logic msg_err;
        logic bcast_rcvd;
        logic term_flag;
        logic test_done;
        logic test_pass;
        logic [2:0] ctrl;
        resp_type resp;
        logic [31:0] prdata;
        logic pslverr;
    } state_type;

    state_type s;
    state_type next_s;

    function automatic logic is_mode_sa(input logic [4:0] sa);
        is_mode_sa = (sa == sa_mode_lo) || (sa == sa_mode_hi); // R5
    endfunction

    // odd parity over address and parity pin
    function automatic logic par_ok(input logic [4:0] a, input logic p);
        par_ok = ^{a, p};
    endfunction

    function automatic logic [15:0] status_word(input state_type st);
        logic [15:0] w;
        w = 16'h0000; // R17
        w[15:11] = st.addr_a;
        w[10] = st.msg_err; // R17
        w[9] = 1'b0; // R17
        w[8] = st.ctrl[ctrl_sreq_bit];
        w[7:5] = 3'h0; // R17
        w[4] = st.bcast_rcvd; // R18
        w[3] = (st.phase == ph_reset) || (st.phase == ph_test); // R22
        w[2] = subsys_fault; // R19
        w[1] = 1'b0; // R21
        w[0] = st.term_flag; // R20
        status_word = w; // R16
    endfunction

    logic own;
    logic bcast;
    logic mode;
    logic hit;
    logic can_reply;
    logic self_ok;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [15:0] cur_status;

    always_comb begin
        own = cmd.valid && s.addr_ok && (cmd.rt_addr == s.addr_a) && (s.addr_a == s.addr_b); // R4
        bcast = cmd.valid && s.addr_ok && (cmd.rt_addr == addr_bcast) && s.ctrl[ctrl_bcast_bit]; // R23
        mode = is_mode_sa(cmd.subaddr);
        hit = own || bcast;
        can_reply = own && !s.tx_off[cmd.bus];
        self_ok = (s.addr_a == s.addr_b) && par_ok(s.addr_a, s.par_a) && (s.addr_a != addr_bcast);
        cur_status = status_word(s);
    end

    // register read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == off_ctrl) begin
            rd_word[2:0] = s.ctrl;
        end else if (paddr == off_status) begin
            rd_word[15:0] = cur_status;
            rd_word[stat_addr_ok_bit] = s.addr_ok;
            rd_word[stat_tx_off_lsb +: 2] = s.tx_off;
            rd_word[stat_busy_bit] = cur_status[3];
            rd_word[stat_fail_bit] = (s.phase == ph_dead);
        end else if (paddr == off_result) begin
            rd_word[0] = s.test_done;
            rd_word[1] = s.test_pass;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        next_s = s;
        next_s.sync1 = {addr_par_pin, addr_pin}; // R2
        next_s.sync2 = s.sync1;
        next_s.resp.valid = 1'b0;

        // apb: data and error captured in setup, shown in access
        if (psel && !penable) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : rd_word;
            next_s.pslverr = !rd_hit || (pwrite && (paddr != off_ctrl));
        end
        if (psel && penable && pwrite && (paddr == off_ctrl)) begin
            next_s.ctrl = pwdata[2:0];
        end

        case (s.phase)
            ph_acquire: begin
                next_s.acq_cnt = s.acq_cnt + 4'h1;
                if (s.acq_cnt == acq_settle) begin
                    next_s.addr_a = s.sync2[4:0]; // R3
                    next_s.par_a = s.sync2[5];
                    next_s.acq_cnt = 4'h0;
                    next_s.phase = ph_check;
                end
            end
            ph_check: begin
                next_s.acq_cnt = s.acq_cnt + 4'h1;
                if (s.acq_cnt == acq_settle) begin
                    // second independent sample must match and pass parity
                    next_s.addr_b = s.sync2[4:0]; // R3
                    if ((s.sync2[4:0] == s.addr_a) && (s.sync2[5] == s.par_a) && par_ok(s.addr_a, s.par_a)
                        && (s.addr_a != addr_bcast)) begin // R1
                        next_s.addr_ok = 1'b1;
                        next_s.phase = ph_idle;
                    end else begin
                        next_s.phase = ph_dead; // R4
                    end
                end
            end
            ph_reset: begin
                next_s.cnt = s.cnt + 24'h1;
                if (s.cnt >= 24'(reset_cycles - 1)) begin
                    // status flags and bus enables back to power-up values, address and self test result kept
                    next_s.tx_off = 2'b00; // R11
                    next_s.msg_err = 1'b0;
                    next_s.bcast_rcvd = 1'b0;
                    next_s.term_flag = 1'b0;
                    next_s.cnt = 24'h0;
                    next_s.phase = ph_idle;
                end
            end
            ph_test: begin
                next_s.cnt = s.cnt + 24'h1;
                if (s.cnt >= 24'(test_cycles - 1)) begin
                    next_s.test_done = 1'b1; // R15
                    next_s.test_pass = self_ok;
                    next_s.term_flag = !self_ok; // R20
                    next_s.cnt = 24'h0;
                    next_s.phase = ph_idle;
                end
            end
            ph_reset_wait: begin
                if (resp_sent) begin
                    next_s.cnt = 24'h0;
                    next_s.phase = ph_reset; // R9
                end
            end
            ph_test_wait: begin
                if (resp_sent) begin
                    next_s.cnt = 24'h0;
                    next_s.phase = ph_test; // R12
                end
            end
            default: begin
            end
        endcase

        // command handling
        if (hit && (s.phase == ph_reset)) begin
            // only a busy status while resetting, no data
            if (can_reply) begin
                next_s.resp.valid = 1'b1; // R10
                next_s.resp.bus = cmd.bus;
                next_s.resp.word = cur_status;
            end
        end else if (hit && ((s.phase == ph_idle) || (s.phase == ph_test) || (s.phase == ph_test_wait)
                             || (s.phase == ph_reset_wait))) begin
            if (s.phase == ph_test) begin
                next_s.phase = ph_idle; // R13
                next_s.cnt = 24'h0;
            end else if (s.phase != ph_idle) begin
                next_s.phase = ph_idle;
            end
            next_s.resp.valid = can_reply; // R14
            next_s.resp.bus = cmd.bus;
            next_s.resp.word = cur_status;
            if (bcast) begin
                next_s.bcast_rcvd = 1'b1; // R18
            end
            if (mode && (cmd.mode != mc_tx_status) && !bcast) begin
                next_s.bcast_rcvd = 1'b0;
                next_s.msg_err = 1'b0;
            end
            if (!mode && !bcast) begin
                next_s.bcast_rcvd = 1'b0;
                next_s.msg_err = 1'b0;
            end
            if (mode) begin
                case (cmd.mode)
                    mc_tx_status: begin
                        // reply carries stored status unchanged
                        next_s.resp.word = cur_status; // R7
                    end
                    mc_tx_shutdown: begin
                        next_s.tx_off[!cmd.bus] = 1'b1; // R7
                    end
                    mc_tx_override: begin
                        next_s.tx_off[!cmd.bus] = 1'b0; // R7
                    end
                    mc_reset_rt: begin
                        next_s.cnt = 24'h0;
                        next_s.phase = can_reply ? ph_reset_wait : ph_reset; // R9
                    end
                    mc_self_test: begin
                        if (s.ctrl[ctrl_test_bit]) begin
                            next_s.test_done = 1'b0;
                            next_s.test_pass = 1'b0;
                            next_s.cnt = 24'h0;
                            next_s.phase = can_reply ? ph_test_wait : ph_test; // R12
                        end else begin
                            next_s.msg_err = !bcast;
                            next_s.resp.word[10] = !bcast;
                        end
                    end
                    default: begin
                        // unsupported mode code to own address flags a message error
                        next_s.msg_err = !bcast;
                        next_s.resp.word[10] = !bcast;
                    end
                endcase
            end
        end

        // an error in the same cycle as a clearing command wins
        if (msg_error && s.addr_ok && (s.phase != ph_reset)) begin
            next_s.msg_err = 1'b1; // R17
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.sync1 <= 6'h00;
            s.sync2 <= 6'h00;
            s.phase <= ph_acquire;
            s.acq_cnt <= 4'h0;
            s.addr_a <= 5'h00;
            s.addr_b <= 5'h00;
            s.par_a <= 1'b0;
            s.addr_ok <= 1'b0;
            s.cnt <= 24'h0;
            s.tx_off <= 2'b00;
            s.msg_err <= 1'b0;
            s.bcast_rcvd <= 1'b0;
            s.term_flag <= 1'b0;
            s.test_done <= 1'b0;
            s.test_pass <= 1'b0;
            s.ctrl <= ctrl_reset;
            s.resp <= '0;
            s.prdata <= 32'h0000_0000;
            s.pslverr <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = s.pslverr && psel && penable;
    assign resp = s.resp;
    assign tx_enable = ~s.tx_off;
    assign addr_valid = s.addr_ok;
    assign busy = (s.phase == ph_reset) || (s.phase == ph_test); // R22

endmodule

/* tb/rt_ctl_properties.sv */
`timescale 1ns/1ps
module rt_ctl_properties
    import rt_ctl_pkg::*;
#(
    parameter int unsigned reset_cycles = 20,
    parameter int unsigned test_cycles = 40
) (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // terminal side
    input wire logic [4:0] addr_pin,
    input wire logic addr_par_pin,
    input wire cmd_type cmd,
    input wire logic msg_error,
    input wire logic subsys_fault,
    input wire resp_type resp,
    input wire logic resp_sent,
    input wire logic [1:0] tx_enable,
    input wire logic addr_valid,
    input wire logic busy
);
    logic [4:0] last_mode;
    int unsigned busy_cnt;
    logic own_mode;
    assign own_mode = cmd.valid && addr_valid && cmd.rt_addr == addr_pin && !busy && tx_enable[cmd.bus]
        && (cmd.subaddr == sa_mode_lo || cmd.subaddr == sa_mode_hi);
    // mode of the last idle command and length of the busy run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_mode <= 5'h00;
            busy_cnt <= 0;
        end else begin
            if (cmd.valid && !busy) last_mode <= cmd.mode;
            busy_cnt <= busy ? busy_cnt + 1 : 0;
        end
    end
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    addr_accept_a: assert property ($rose(addr_valid) |-> addr_pin != addr_bcast && ^{addr_pin, addr_par_pin})
        else $error("address accepted although reserved or of bad parity");
    reply_own_addr_a: assert property (resp.valid |-> addr_valid && $past(cmd.valid) && $past(cmd.rt_addr) == addr_pin)
        else $error("reply without a command to our valid address");
    reply_bus_on_a: assert property (resp.valid |-> tx_enable[resp.bus])
        else $error("reply on a shut bus");
    zero_bits_a: assert property (resp.valid |-> resp.word[9] == 1'b0 && resp.word[7:5] == 3'h0 && !resp.word[1])
        else $error("reserved or instrumentation bit set");
    addr_field_a: assert property (resp.valid |-> resp.word[15:11] == addr_pin)
        else $error("status address field wrong");
    busy_cause_a: assert property (resp.valid && !$past(busy) |-> !resp.word[3])
        else $error("busy bit without cause");
    shutdown_other_a: assert property (own_mode && cmd.mode == mc_tx_shutdown |=> !tx_enable[!$past(cmd.bus)])
        else $error("shutdown left other bus on");
    override_other_a: assert property (own_mode && cmd.mode == mc_tx_override |=> tx_enable[!$past(cmd.bus)])
        else $error("override left other bus off");
    reset_reply_a: assert property (own_mode && cmd.mode == mc_reset_rt |=> resp.valid && !busy)
        else $error("reset did not reply first");
    reset_limit_a: assert property (busy && last_mode == mc_reset_rt |-> busy_cnt <= reset_cycles)
        else $error("reset ran too long");
    test_limit_a: assert property (busy && last_mode == mc_self_test |-> busy_cnt <= test_cycles)
        else $error("self test ran too long");
    cover property (resp.valid && resp.word[3]);
    cover property ($fell(busy));
    cover property (resp.valid && resp.word[4]);
endmodule
bind rt_option_mode_status_logic rt_ctl_properties #(.reset_cycles(reset_cycles), .test_cycles(test_cycles))
    rt_ctl_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .addr_pin(addr_pin),
    .addr_par_pin(addr_par_pin), .cmd(cmd), .msg_error(msg_error), .subsys_fault(subsys_fault), .resp(resp),
    .resp_sent(resp_sent), .tx_enable(tx_enable), .addr_valid(addr_valid), .busy(busy));

/* tb/bc_model.sv */
`timescale 1ns/1ps
module bc_model
    import rt_ctl_pkg::*;
(
    // clock
    input wire logic pclk,
    // command and encoder side
    output cmd_type cmd,
    input wire resp_type resp,
    output logic resp_sent
);
    int gap = 2;
    initial begin
        cmd = '0;
        resp_sent = 1'b0;
    end
    // codes the bench passes in, named or literal, either mode subaddress, never dynamic control
    task automatic send(input logic bus, input logic [4:0] rt, input logic [4:0] sa, input logic [4:0] mc);
        @(posedge pclk);
        cmd <= '{1'b1, bus, rt, 1'b1, sa, mc};
        @(posedge pclk);
        cmd <= cmd_type'({1'b0, ~cmd[16:0]});
    endtask
    int left = 0;
    // reply sent pulse some cycles after the latest reply, each reply restarting the count
    always @(posedge pclk) begin
        resp_sent <= (left == 1);
        if (resp.valid === 1'b1) left <= gap + 1;
        else if (left > 0) left <= left - 1;
    end
endmodule

/* tb/rt_option_mode_status_logic_tb.sv */
`timescale 1ns/1ps
module rt_option_mode_status_logic_tb;
    import rt_ctl_pkg::*;
    localparam int unsigned rcyc = 20;
    localparam int unsigned tcyc = 40;
    logic pclk = 1'b0;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, addr_par_pin = 1'b0;
    logic msg_error = 1'b0, subsys_fault = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0] addr_pin = 5'h00, own;
    logic pready, pslverr, resp_sent, addr_valid, busy, err;
    logic [1:0] tx_enable;
    cmd_type cmd;
    resp_type resp;
    logic [16:0] notes[$];
    int error_cnt = 0;
    int checked = 0;
    rt_option_mode_status_logic #(.reset_cycles(rcyc), .test_cycles(tcyc)) rt_option_mode_status_logic_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .addr_pin(addr_pin),
        .addr_par_pin(addr_par_pin), .cmd(cmd), .msg_error(msg_error), .subsys_fault(subsys_fault),
        .resp(resp), .resp_sent(resp_sent), .tx_enable(tx_enable), .addr_valid(addr_valid), .busy(busy));
    bc_model bc_model_inst (.pclk(pclk), .cmd(cmd), .resp(resp), .resp_sent(resp_sent));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_on(ref logic sig, input logic lvl, input int lim);
        int n = 0;
        while (sig !== lvl && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (sig !== lvl) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        wait_on(pready, 1'b1, 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // f holds message error, service request, broadcast, busy, subsystem flag, terminal flag
    task automatic ask(input logic bus, input logic [4:0] sa, input logic [4:0] mc, input logic hear,
                       input logic [5:0] f);
        if (hear) notes.push_back({bus, own, f[5], 1'b0, f[4], 3'h0, f[3:1], 1'b0, f[0]});
        bc_model_inst.send(bus, own, sa, mc);
        repeat (2) @(posedge pclk);
    endtask
    task automatic boot(input logic [4:0] a, input logic good);
        presetn <= 1'b0;
        addr_pin <= a;
        addr_par_pin <= ~^a ^ ~good;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    always @(negedge pclk) begin
        if (resp.valid === 1'b1) begin
            if (notes.size() == 0) check("unexpected reply", 32'h1, 32'h0);
            else check("bus and status word", 32'({resp.bus, resp.word}), 32'(notes.pop_front()));
        end
    end
    initial begin
        forever #4 pclk = ~pclk;
    end
    initial begin
        #(8 * 20000);
        error_cnt++;
        complete_run();
    end
    initial begin
        rd = $urandom(66142);
        own = 5'($urandom % 31);
        boot(own, 1'b1);
        wait_on(addr_valid, 1'b1, 40);
        apb(1'b0, off_ctrl, 32'h0);
        check("ctrl reset", rd, 32'h3);
        apb(1'b0, off_status, 32'h0);
        check("status flags", 32'(rd[20:16]), 32'h1);
        apb(1'b1, off_status, 32'h0);
        check("read-only error", 32'(err), 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        check("unmapped error", 32'(err), 32'h1);
        for (int i = 0; i < 4; i++) ask(i[0], i[1] ? sa_mode_hi : sa_mode_lo, mc_tx_status, 1'b1, 6'h00);
        ask(1'b0, sa_mode_hi, mc_tx_shutdown, 1'b1, 6'h00);
        check("tx after shutdown", 32'(tx_enable), 32'h1);
        ask(1'b1, sa_mode_lo, mc_tx_status, 1'b0, 6'h00);
        ask(1'b0, sa_mode_lo, mc_tx_override, 1'b1, 6'h00);
        ask(1'b1, sa_mode_lo, mc_tx_status, 1'b1, 6'h00);
        apb(1'b1, off_ctrl, 32'h7);
        subsys_fault <= 1'b1;
        ask(1'b0, sa_mode_lo, mc_tx_status, 1'b1, 6'h12);
        subsys_fault <= 1'b0;
        apb(1'b1, off_ctrl, 32'h3);
        bc_model_inst.send(1'b0, addr_bcast, sa_mode_lo, mc_tx_status);
        msg_error <= 1'b1;
        @(posedge pclk);
        msg_error <= 1'b0;
        ask(1'b0, sa_mode_lo, mc_tx_status, 1'b1, 6'h28);
        ask(1'b0, sa_mode_lo, 5'h11, 1'b1, 6'h28);
        ask(1'b0, sa_mode_lo, mc_tx_shutdown, 1'b1, 6'h20);
        bc_model_inst.gap = 6;
        ask(1'b0, sa_mode_lo, mc_reset_rt, 1'b1, 6'h00);
        wait_on(busy, 1'b1, 20);
        ask(1'b0, sa_mode_lo, mc_tx_status, 1'b1, 6'h04);
        wait_on(busy, 1'b0, rcyc + 10);
        check("tx after reset", 32'(tx_enable), 32'h3);
        ask(1'b1, sa_mode_lo, mc_tx_status, 1'b1, 6'h00);
        bc_model_inst.gap = 0;
        ask(1'b0, sa_mode_hi, mc_self_test, 1'b1, 6'h00);
        wait_on(busy, 1'b1, 10);
        wait_on(busy, 1'b0, tcyc + 10);
        apb(1'b0, off_result, 32'h0);
        check("self test result", rd, 32'h3);
        ask(1'b0, sa_mode_lo, mc_self_test, 1'b1, 6'h00);
        wait_on(busy, 1'b1, 10);
        ask(1'b0, sa_mode_lo, mc_tx_status, 1'b1, 6'h04);
        check("busy after abort", 32'(busy), 32'h0);
        apb(1'b1, off_ctrl, 32'h0);
        ask(1'b0, sa_mode_lo, mc_self_test, 1'b1, 6'h20);
        bc_model_inst.send(1'b0, addr_bcast, sa_mode_lo, mc_tx_status);
        ask(1'b0, sa_mode_hi, mc_tx_status, 1'b1, 6'h20);
        for (int i = 0; i < 2; i++) begin
            boot(i[0] ? addr_bcast : own, i[0]);
            repeat (40) @(posedge pclk);
            check("bad address taken", 32'(addr_valid), 32'h0);
            ask(1'b0, sa_mode_lo, mc_tx_status, 1'b0, 6'h00);
        end
        apb(1'b0, off_status, 32'h0);
        check("address invalid flag", 32'(rd[20]), 32'h1);
        own = 5'h1e;
        boot(own, 1'b1);
        wait_on(addr_valid, 1'b1, 40);
        ask(1'b1, sa_mode_hi, mc_tx_status, 1'b1, 6'h00);
        check("replies missing", 32'(notes.size()), 32'h0);
        complete_run();
    end
endmodule
